//--- core/vtad_pkg.sv
// constants and carriers for the vector table and address decode block
// assumes one 100 MHz clock, a synchronous active-low reset, and word addresses
// What this block does
// R01: each vector slot is two words
// R02: handler reach limited to 19-bit addresses
// R03: base offsets 0 and 2 are reset overlays
// R04: reset base overlays boot and watchdog words
// R05: vectors 2 to 5 fixed at level 3
// R06: debug vectors 6 to 10 programmable 1-3
// R07: soft vectors 11-13 levels 2-0, 45 lowest
// R08: peripheral vectors programmable 0-2, reserved never requested
// R09: flash raises separate vectors 18, 19, 20
// R10: converter raises vectors 40, 41, 42
// R11: all decoded addresses are 16-bit words
// R12: program decode flash, RAM, else reserved
// R13: data RAM aliases program RAM; peripherals; debug
// R14: serve by level, then lowest vector
// R15: table location comes from vector base
// R16: nothing pending above mask gives no request
package vtad_pkg;

    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned VEC_W       = 6;
    localparam int unsigned LVL_W       = 3;
    localparam int unsigned NUM_VECTORS = 46;
    localparam int unsigned HANDLER_W   = 19;
    localparam int unsigned RAM_WORD_W  = 11;
    localparam int unsigned DBG_FIRST   = 6;
    localparam int unsigned DBG_COUNT   = 5;
    localparam int unsigned PER_FIRST   = 16;
    localparam int unsigned PER_COUNT   = 29;

    // level codes: ordered so that a plain compare gives precedence
    localparam logic [2:0] LVL_OFF = 3'h0;
    localparam logic [2:0] LVL_M1  = 3'h1;
    localparam logic [2:0] LVL_0   = 3'h2;
    localparam logic [2:0] LVL_1   = 3'h3;
    localparam logic [2:0] LVL_2   = 3'h4;
    localparam logic [2:0] LVL_3   = 3'h5;

    localparam logic [23:0] VBASE_RST  = 24'h000000;
    localparam logic [23:0] BOOT_OFF   = 24'h000000;
    localparam logic [23:0] WDOG_OFF   = 24'h000002;
    localparam logic [23:0] FLASH_LO   = 24'h000000;
    localparam logic [23:0] FLASH_HI   = 24'h001FFF;
    localparam logic [23:0] PRAM_LO    = 24'h008000;
    localparam logic [23:0] PRAM_HI    = 24'h0087FF;
    localparam logic [23:0] DRAM_LO    = 24'h000000;
    localparam logic [23:0] DRAM_HI    = 24'h0007FF;
    localparam logic [23:0] PERIPH_LO  = 24'h00F000;
    localparam logic [23:0] PERIPH_HI  = 24'h00FFFF;
    localparam logic [23:0] DEBUG_LO   = 24'hFFFF00;
    localparam logic [23:0] DEBUG_HI   = 24'hFFFFFF;

    typedef struct packed {
        logic        req;
        logic [5:0]  vector;
        logic [2:0]  level;
        logic [23:0] slot;
    } vtad_irq_s;

    typedef struct packed {
        logic        flash;
        logic        ram;
        logic        rsvd;
        logic [10:0] ram_word;
    } vtad_psel_s;

    typedef struct packed {
        logic        ram;
        logic        periph;
        logic        debug;
        logic        rsvd;
        logic [10:0] ram_word;
    } vtad_dsel_s;

endpackage

//--- core/vtad_addr_decode.sv
// program and data space word-address decode, registered selects
// assumes addresses are presented synchronous to clock_in
`timescale 1ns/100ps
module vtad_addr_decode (
    input  logic                 clock_in,
    input  logic                 rst_b_in,
    input  logic [23:0]          prog_addr_in,
    input  logic [23:0]          data_addr_in,
    output vtad_pkg::vtad_psel_s psel_out,
    output vtad_pkg::vtad_dsel_s dsel_out
);

    function automatic logic in_range(input logic [23:0] a,
                                      input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // every address is a word index, never shifted by byte lanes (see R11)
    wire p_flash = in_range(prog_addr_in, vtad_pkg::FLASH_LO,
                            vtad_pkg::FLASH_HI); // see R12
    wire p_ram   = in_range(prog_addr_in, vtad_pkg::PRAM_LO,
                            vtad_pkg::PRAM_HI); // see R12
    wire d_ram   = in_range(data_addr_in, vtad_pkg::DRAM_LO,
                            vtad_pkg::DRAM_HI); // see R13
    wire d_per   = in_range(data_addr_in, vtad_pkg::PERIPH_LO,
                            vtad_pkg::PERIPH_HI); // see R13
    wire d_dbg   = in_range(data_addr_in, vtad_pkg::DEBUG_LO,
                            vtad_pkg::DEBUG_HI); // see R13
    wire [23:0] p_off = prog_addr_in - vtad_pkg::PRAM_LO;
    wire [23:0] d_off = data_addr_in - vtad_pkg::DRAM_LO;

    vtad_pkg::vtad_psel_s psel_d;
    vtad_pkg::vtad_dsel_s dsel_d;
    assign psel_d = '{flash: p_flash, ram: p_ram,
                      rsvd: !(p_flash || p_ram),
                      ram_word: p_ram ? p_off[10:0] : 11'h000};
    // both spaces land on the same RAM word index (see R13)
    assign dsel_d = '{ram: d_ram, periph: d_per, debug: d_dbg,
                      rsvd: !(d_ram || d_per || d_dbg),
                      ram_word: d_ram ? d_off[10:0] : 11'h000};

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            psel_out <= '0;
            dsel_out <= '0;
        end else begin
            psel_out <= psel_d;
            dsel_out <= dsel_d;
        end
    end

    AST_PFLASH: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> psel_out.flash
            == ($past(prog_addr_in) <= vtad_pkg::FLASH_HI)) // see R12
        else $error("program flash select wrong");
    AST_RAM_ALIAS: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (prog_addr_in == (data_addr_in + vtad_pkg::PRAM_LO)) && d_ram
            |=> psel_out.ram && dsel_out.ram
                && psel_out.ram_word == dsel_out.ram_word) // see R13
        else $error("data RAM does not alias program RAM");
    AST_DEBUG_SEL: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        data_addr_in[23:8] == 16'hFFFF |=> dsel_out.debug
            && !dsel_out.periph && !dsel_out.rsvd) // see R13
        else $error("debug window not selected");

endmodule

//--- core/vtad_vector_ctrl.sv
// interrupt vector table, priority arbitration and address decode top
// assumes level-sensitive sources held until serviced, synchronous inputs
`timescale 1ns/100ps
module vtad_vector_ctrl #(
    parameter int unsigned NUM_VECTORS = vtad_pkg::NUM_VECTORS
) (
    input  logic                   clock_in,
    input  logic                   rst_b_in,
    input  logic [NUM_VECTORS-1:0] src_in,
    input  logic [9:0]             dbg_prio_in,
    input  logic [57:0]            per_prio_in,
    input  logic [2:0]             mask_level_in,
    input  logic                   vector_base_wr_in,
    input  logic [23:0]            vector_base_in,
    input  logic [23:0]            handler_target_in,
    input  logic [23:0]            prog_addr_in,
    input  logic [23:0]            data_addr_in,
    output vtad_pkg::vtad_irq_s    irq_out,
    output logic [23:0]            boot_slot_out,
    output logic [23:0]            wdog_slot_out,
    output logic                   handler_reach_ok_out,
    output vtad_pkg::vtad_psel_s   psel_out,
    output vtad_pkg::vtad_dsel_s   dsel_out
);

    // level of vector n; 0 in a 2-bit priority field disables the source
    function automatic logic [2:0] vtad_level(input int n,
                                              input logic [9:0] dbg,
                                              input logic [57:0] per);
        logic [1:0] p;
        p = 2'h0;
        vtad_level = vtad_pkg::LVL_OFF;
        if (n >= 2 && n <= 5) begin
            vtad_level = vtad_pkg::LVL_3; // see R05
        end else if (n >= 6 && n <= 10) begin
            p = dbg[2*(n-6) +: 2];
            if (p != 2'h0) begin
                vtad_level = 3'(vtad_pkg::LVL_0 + {1'b0, p}); // see R06
            end
        end else if (n == 11) begin
            vtad_level = vtad_pkg::LVL_2; // see R07
        end else if (n == 12) begin
            vtad_level = vtad_pkg::LVL_1; // see R07
        end else if (n == 13) begin
            vtad_level = vtad_pkg::LVL_0; // see R07
        end else if (n >= 16 && n <= 44 && n != 21 && n != 33 && n != 34) begin
            // flash 18-20 and converter 40-42 keep separate vectors
            p = per[2*(n-16) +: 2]; // see R09 see R10
            if (p != 2'h0) begin
                vtad_level = 3'(vtad_pkg::LVL_M1 + {1'b0, p}); // see R08
            end
        end else if (n == 45) begin
            vtad_level = vtad_pkg::LVL_M1; // see R07
        end
    endfunction

    logic [23:0] vbase_q;
    logic [2:0]  lvl_w [NUM_VECTORS];
    logic [2:0]  best_lvl;
    logic [5:0]  best_vec;
    logic [NUM_VECTORS-1:0] src_q;
    vtad_pkg::vtad_irq_s irq_d;

    // vectors 0, 1 and the reserved numbers always decode to off (see R03)
    for (genvar g = 0; g < NUM_VECTORS; g++) begin : g_lvl
        assign lvl_w[g] = vtad_level(g, dbg_prio_in, per_prio_in); // see R08
    end

    // descending scan with >= lets the lower vector win a tie (see R14)
    always_comb begin
        best_lvl = vtad_pkg::LVL_OFF;
        best_vec = 6'h00;
        for (int n = NUM_VECTORS - 1; n >= 2; n--) begin
            if (src_in[n] && lvl_w[n] != vtad_pkg::LVL_OFF
                && lvl_w[n] >= best_lvl) begin
                best_lvl = lvl_w[n];
                best_vec = 6'(n);
            end
        end
    end

    wire any_above = best_lvl > mask_level_in; // see R16
    wire [23:0] slot_w = 24'(vbase_q + {17'h00000, best_vec, 1'b0}); // see R01

    assign irq_d = '{req: any_above,
                     vector: any_above ? best_vec : 6'h00,
                     level: any_above ? best_lvl : vtad_pkg::LVL_OFF,
                     slot: any_above ? slot_w : 24'h000000};

    // the slot holds one instruction word pair, so the target must fit
    wire reach_ok = handler_target_in[23:vtad_pkg::HANDLER_W] == 5'h00;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            vbase_q <= vtad_pkg::VBASE_RST; // see R04
        end else if (vector_base_wr_in) begin
            vbase_q <= vector_base_in; // see R15
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            irq_out              <= '0;
            handler_reach_ok_out <= 1'b0;
        end else begin
            irq_out              <= irq_d; // see R16
            handler_reach_ok_out <= reach_ok; // see R02
        end
    end

    // sources as the arbiter saw them, so a grant can be traced back
    always_ff @(posedge clock_in) begin
        src_q <= src_in;
    end

    // overlay slots track the base; at reset they sit on words 0 and 2
    assign boot_slot_out = 24'(vbase_q + vtad_pkg::BOOT_OFF); // see R03
    assign wdog_slot_out = 24'(vbase_q + vtad_pkg::WDOG_OFF); // see R03

    vtad_addr_decode u_decode (
        .clock_in     (clock_in),
        .rst_b_in     (rst_b_in),
        .prog_addr_in (prog_addr_in),
        .data_addr_in (data_addr_in),
        .psel_out     (psel_out),
        .dsel_out     (dsel_out)
    );

    sequence s_core_fault_pending;
        src_in[2] && mask_level_in < vtad_pkg::LVL_3;
    endsequence

    sequence s_vector2_granted;
        irq_out.req && irq_out.vector == 6'h02
            && irq_out.level == vtad_pkg::LVL_3;
    endsequence

    AST_SLOT_ADDR: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        irq_out.req && $stable(vbase_q) |-> irq_out.slot
            == 24'(vbase_q + {17'h00000, irq_out.vector, 1'b0})) // see R01
        else $error("slot not at base plus twice vector");
    AST_REACH: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        handler_target_in[23:19] != 5'h00 |=> !handler_reach_ok_out) // see R02
        else $error("handler outside reach accepted");
    AST_NO_RESERVED: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        irq_out.req |-> !(irq_out.vector inside {6'h00, 6'h01, 6'h0E,
            6'h0F, 6'h15, 6'h21, 6'h22})) // see R03
        else $error("reserved vector requested");
    AST_RESET_BASE: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        $rose(rst_b_in) |-> boot_slot_out == 24'h000000
            && wdog_slot_out == 24'h000002) // see R04
        else $error("reset base does not overlay boot words");
    AST_CORE_FIXED: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        irq_out.req && irq_out.vector inside {[6'h02:6'h05]}
            |-> irq_out.level == vtad_pkg::LVL_3) // see R05
        else $error("core exception not at level 3");
    AST_DEBUG_LEVEL: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        irq_out.req && irq_out.vector inside {[6'h06:6'h0A]}
            |-> irq_out.level inside {[vtad_pkg::LVL_1:vtad_pkg::LVL_3]})
        // see R06
        else $error("debug vector level out of range");
    AST_SOFT_LOW: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        irq_out.req && irq_out.vector == 6'h2D
            |-> irq_out.level == vtad_pkg::LVL_M1
                && src_q[5:2] == 4'h0
                && src_q[13:11] == 3'h0) // see R07
        else $error("low soft interrupt not lowest");
    AST_PERIPH_LEVEL: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        irq_out.req && irq_out.vector inside {[6'h10:6'h2C]}
            |-> irq_out.level inside {[vtad_pkg::LVL_0:vtad_pkg::LVL_2]})
        // see R08
        else $error("peripheral vector level out of range");
    AST_SOURCE_PENDING: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        irq_out.req && $past(rst_b_in)
            |-> src_q[irq_out.vector]) // see R09 see R10
        else $error("granted vector had no pending source");
    AST_PRIORITY: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        s_core_fault_pending |=> s_vector2_granted) // see R14
        else $error("vector 2 lost arbitration");
    AST_BASE_LOAD: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        vector_base_wr_in ##1 !vector_base_wr_in[*2]
            |-> boot_slot_out == $past(vector_base_in, 2)) // see R15
        else $error("vector base not loaded");
    AST_MASKED: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !any_above |=> !irq_out.req && irq_out.vector == 6'h00) // see R16
        else $error("request raised with nothing above mask");

endmodule

//--- testbench/vtad_core_model.sv
// processor core stand-in: presents its mask level, fetches handler slots
// assumes irq_in is the block's registered request, seen combinationally
`timescale 1ns/100ps
module vtad_core_model (
    input  vtad_pkg::vtad_irq_s irq_in,
    input  wire logic [2:0]     mask_req_in,
    input  wire logic           fetch_en_in,
    input  wire logic [23:0]    addr_req_in,
    output logic [2:0]          mask_level_out,
    output logic [23:0]         prog_addr_out
);
    assign mask_level_out = mask_req_in;
    // a fetching core reads the slot of whatever it is asked to serve
    assign prog_addr_out = (fetch_en_in && irq_in.req) ? irq_in.slot
                                                       : addr_req_in;
endmodule

//--- testbench/vtad_vector_ctrl_bench.sv
// random and corner-case bench for the vector table and address decode
// assumes registered outputs one edge after inputs; inputs held two edges
`timescale 1ns/100ps
module vtad_vector_ctrl_bench;
    logic                clock_in = 1'b0;
    logic                rst_b_in = 1'b0;
    logic                wr = 1'b0;
    logic                fetch = 1'b0;
    logic [45:0]         src = '0;
    logic [9:0]          dbg = '0;
    logic [57:0]         per = '0;
    logic [2:0]          mreq = '0;
    logic [2:0]          mask;
    logic [23:0]         vb = '0, tgt = '0, pa = '0, da = '0, base_m = '0;
    logic [23:0]         paddr, boot, wdog;
    logic                rok;
    vtad_pkg::vtad_irq_s  irq;
    vtad_pkg::vtad_psel_s ps;
    vtad_pkg::vtad_dsel_s ds;
    int                  n_mismatch = 0;
    int                  samples_checked = 0;
    logic [31:0]         rs = 32'd53716;
    logic [23:0]         pt [8] = '{24'h001FFF, 24'h002000, 24'h007FFF,
        24'h008000, 24'h0087FF, 24'h008800, 24'hFFFFFF, 24'h000000};
    logic [23:0]         dt [8] = '{24'h0007FF, 24'h000800, 24'h00EFFF,
        24'h00F000, 24'h00FFFF, 24'h010000, 24'hFFFEFF, 24'hFFFF00};

    vtad_core_model core (.irq_in(irq), .mask_req_in(mreq),
        .fetch_en_in(fetch), .addr_req_in(pa), .mask_level_out(mask),
        .prog_addr_out(paddr));
    vtad_vector_ctrl uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .src_in(src), .dbg_prio_in(dbg), .per_prio_in(per),
        .mask_level_in(mask), .vector_base_wr_in(wr),
        .vector_base_in(vb), .handler_target_in(tgt),
        .prog_addr_in(paddr), .data_addr_in(da), .irq_out(irq),
        .boot_slot_out(boot), .wdog_slot_out(wdog),
        .handler_reach_ok_out(rok), .psel_out(ps), .dsel_out(ds));

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    function automatic logic [2:0] lvl(int v);
        logic [1:0] f;
        if (v >= 2 && v <= 5) return 3'h5;
        if (v == 11) return 3'h4;
        if (v == 12) return 3'h3;
        if (v == 13) return 3'h2;
        if (v == 45) return 3'h1;
        if (v >= 6 && v <= 10) begin
            f = dbg[2*(v-6) +: 2];
            return (f == 2'h0) ? 3'h0 : {1'b0, f} + 3'h2;
        end
        if (v >= 16 && v <= 44 && v != 21 && v != 33 && v != 34) begin
            f = per[2*(v-16) +: 2];
            return (f == 2'h0) ? 3'h0 : {1'b0, f} + 3'h1;
        end
        return 3'h0;
    endfunction

    // ascending scan with strict compare keeps the lowest vector on ties
    function automatic vtad_pkg::vtad_irq_s exp_irq();
        vtad_pkg::vtad_irq_s e;
        logic [2:0]          c;
        e = '0;
        for (int v = 0; v < 46; v++) begin
            c = lvl(v);
            if (src[v] && c > mask && c > e.level) begin
                e.req = 1'b1;
                e.vector = 6'(v);
                e.level = c;
            end
        end
        if (e.req) e.slot = base_m + {17'h0, e.vector, 1'b0};
        return e;
    endfunction

    function automatic vtad_pkg::vtad_psel_s exp_p(logic [23:0] a);
        vtad_pkg::vtad_psel_s e;
        e = '0;
        e.flash = (a <= 24'h001FFF);
        e.ram = (a >= 24'h008000 && a <= 24'h0087FF);
        e.rsvd = !e.flash && !e.ram;
        if (e.ram) e.ram_word = a[10:0];
        return e;
    endfunction

    function automatic vtad_pkg::vtad_dsel_s exp_d(logic [23:0] a);
        vtad_pkg::vtad_dsel_s e;
        e = '0;
        e.ram = (a <= 24'h0007FF);
        e.periph = (a >= 24'h00F000 && a <= 24'h00FFFF);
        e.debug = (a >= 24'hFFFF00);
        e.rsvd = !e.ram && !e.periph && !e.debug;
        if (e.ram) e.ram_word = a[10:0];
        return e;
    endfunction

    task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
        samples_checked++;
        if (e !== s) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // two edges: the base loads on the first, the request uses it on the second
    task automatic cyc();
        @(posedge clock_in);
        @(posedge clock_in);
        @(negedge clock_in);
        if (wr) base_m = vb;
        chk("irq", 64'(exp_irq()), 64'(irq));
        chk("boot", 64'(base_m), 64'(boot));
        chk("wdog", 64'(base_m + 24'h2), 64'(wdog));
        chk("reach", 64'(tgt[23:19] == 5'h0), 64'(rok));
        chk("psel", 64'(exp_p(fetch ? exp_irq().slot : pa)), 64'(ps));
        chk("dsel", 64'(exp_d(da)), 64'(ds));
    endtask

    task automatic go(logic [45:0] s, logic [2:0] m, logic [23:0] p,
                      logic [23:0] d);
        @(posedge clock_in);
        src <= s;
        mreq <= m;
        pa <= p;
        da <= d;
        cyc();
    endtask

    initial begin
        repeat (5000) @(posedge clock_in);
        n_mismatch++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        repeat (16) @(posedge clock_in);
        rst_b_in <= 1'b1;
        go('0, 3'h0, '0, '0);
        for (int i = 0; i < 8; i++) go('0, 3'h0, pt[i], dt[i]);
        dbg <= 10'h3FF;
        per <= '1;
        go(46'h0600_0020_C003, 3'h0, '0, '0);
        for (int m = 0; m < 6; m++) go('1, 3'(m), '0, '0);
        go(46'h0000_0000_07C8, 3'h0, '0, '0);
        go(46'h1 << 45, 3'h0, '0, '0);
        go(46'h1 << 45, 3'h1, '0, '0);
        go(46'h0000_001C_0000, 3'h2, '0, '0);
        go(46'h0700_0000_0000, 3'h2, '0, '0);
        // fetch the slot of vector 19 from a base placed in RAM
        @(posedge clock_in);
        wr <= 1'b1;
        vb <= 24'h008000;
        fetch <= 1'b1;
        go(46'h1 << 19, 3'h0, '0, '0);
        for (int i = 0; i < 400; i++) begin
            @(posedge clock_in);
            r = xs();
            src <= 46'({xs(), xs()} & {xs(), xs()});
            dbg <= 10'(xs());
            per <= 58'({xs(), xs()});
            mreq <= 3'(xs() % 6);
            wr <= (r[7:4] == 4'h0);
            vb <= 24'(xs());
            fetch <= 1'b0;
            tgt <= r[2] ? 24'h07FFFF + {23'h0, r[3]} : r[31:8];
            pa <= r[0] ? {8'h00, r[23:8]} : r[31:8];
            da <= r[1] ? {8'h00, r[31:16]} : {r[15:8], 16'hFF00 | r[31:16]};
            cyc();
        end
        final_report();
    end
endmodule
